// file: hw/lpmc_pkg.sv
// low-power mode controller: shared constants, state encoding, state record
// assumes a single 25 MHz core clock and a word-wide register port
package lpmc_pkg;

  // ------------------------------------------------------------
  // register map and field layout
  // ------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam int          CNT_W           = 12;
  localparam logic [7:0]  CTRL_OFS        = 8'h00;
  localparam logic [7:0]  CSTS_OFS        = 8'h04;
  localparam int          CTRL_LP_BIT     = 0;
  localparam int          CTRL_PD_BIT     = 1;
  localparam int          CTRL_WCLR_BIT   = 2;
  localparam int          CTRL_SCLR_BIT   = 3;
  localparam int          CSTS_WFLAG_BIT  = 0;
  localparam int          CSTS_SBFLAG_BIT = 1;
  localparam int          CSTS_WPEN_BIT   = 8;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
  localparam logic [31:0] CSTS_RST        = 32'h0000_0000;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 40;
  localparam int OSC_STARTUP_NS   = 2000;
  localparam int REG_RECOVERY_NS  = 4000;
  localparam int CHIP_RESET_NS    = 8000;
  localparam int WFLAG_CLR_CYCLES = 2;

  // least time rounds up to whole cycles, never below one
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int OSC_STARTUP_CYC  = ns_to_cycles(OSC_STARTUP_NS);
  localparam int REG_RECOVERY_CYC = ns_to_cycles(REG_RECOVERY_NS);
  localparam int CHIP_RESET_CYC   = ns_to_cycles(CHIP_RESET_NS);

  // ------------------------------------------------------------
  // power states, one-hot
  // ------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_RUN       = 7'h01,
    ST_PEND      = 7'h02,
    ST_SLEEP     = 7'h04,
    ST_STOP      = 7'h08,
    ST_STOP_WAKE = 7'h10,
    ST_STANDBY   = 7'h20,
    ST_RST_HOLD  = 7'h40
  } lpmc_state_t;

  // whole state of the controller
  typedef struct packed {
    lpmc_state_t       state;
    lpmc_state_t       target;
    logic              via_event;
    logic [CNT_W-1:0]  cnt;
    logic              reg_lp;
    logic              reg_pd;
    logic              wpin_en;
    logic              wflag;
    logic              sbflag;
    logic [1:0]        wclr_pipe;
    logic              wake_pin_q;
    logic              core_halt;
    logic              periph_halt;
    logic              reg_low_power;
    logic              domain_off;
    logic              chip_reset;
    logic              take_irq;
    logic              resume_event;
    logic [31:0]       rdata;
    logic              rvalid;
  } lpmc_regs_t;

endpackage

// file: hw/lpmc_ctrl.sv
// low-power mode controller: picks sleep, stop or standby on a wait
// instruction, runs wake-up and exit latency, holds the two registers
// assumes the core pulses the wait inputs for one cycle when the
// instruction completes, and all inputs are synchronous to i_core_clk
`timescale 1ns/100ps
`default_nettype none

module lpmc_ctrl #(
  parameter int OSC_CYC = lpmc_pkg::OSC_STARTUP_CYC,
  parameter int REG_CYC = lpmc_pkg::REG_RECOVERY_CYC,
  parameter int RST_CYC = lpmc_pkg::CHIP_RESET_CYC
) (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_wait_for_interrupt_instr,
  input  wire logic                        i_wait_for_event_instr,
  input  wire logic                        i_deep_sleep_request,
  input  wire logic                        i_sleep_on_handler_return,
  input  wire logic                        i_handler_return,
  input  wire logic                        i_irq_pending,
  input  wire logic                        i_wake_event,
  input  wire logic                        i_wake_pin,
  input  wire logic                        i_rtc_event,
  input  wire logic                        i_external_reset_pin_n,
  input  wire logic                        i_independent_watchdog_rst,
  input  wire logic                        i_reg_wr,
  input  wire logic                        i_reg_rd,
  input  wire logic [lpmc_pkg::ADDR_W-1:0] i_reg_addr,
  input  wire logic [31:0]                 i_reg_wdata,
  output logic [31:0]                      o_reg_rdata,
  output logic                             o_reg_rvalid,
  output logic [6:0]                       o_power_state,
  output logic                             o_core_clk_halt,
  output logic                             o_periph_clk_halt,
  output logic                             o_regulator_low_power,
  output logic                             o_domain_power_off,
  output logic                             o_chip_reset,
  output logic                             o_take_interrupt,
  output logic                             o_resume_event
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // target mode from the values sampled at the wait instruction
  function automatic lpmc_pkg::lpmc_state_t pick_mode(
    input logic deep, input logic pd, input logic flag);
    if (!deep) begin
      return lpmc_pkg::ST_SLEEP;
    end else if (!pd) begin
      return lpmc_pkg::ST_STOP;
    end else if (!flag) begin
      return lpmc_pkg::ST_STANDBY;
    end
    return lpmc_pkg::ST_RUN;                     // blocked entry
  endfunction

  // stop exit length, oscillator plus regulator when it was low power
  function automatic logic [lpmc_pkg::CNT_W-1:0] stop_exit_len(
    input logic lp);
    return lp ? lpmc_pkg::CNT_W'(OSC_CYC + REG_CYC)
              : lpmc_pkg::CNT_W'(OSC_CYC);
  endfunction

  lpmc_pkg::lpmc_regs_t r;
  lpmc_pkg::lpmc_regs_t next_r;

  logic wait_cmd;
  logic wr_ctrl;
  logic wr_csts;
  logic wake_match;
  logic standby_wake;
  logic flag_set;

  // ------------------------------------------------------------
  // decode of requests and wake sources
  // ------------------------------------------------------------
  assign wait_cmd     = i_wait_for_interrupt_instr | i_wait_for_event_instr;
  assign wr_ctrl      = i_reg_wr && (i_reg_addr == lpmc_pkg::CTRL_OFS);
  assign wr_csts      = i_reg_wr && (i_reg_addr == lpmc_pkg::CSTS_OFS);
  // wfi wakes on any interrupt, wfe only on an event
  assign wake_match   = r.via_event ? i_wake_event : i_irq_pending;
  // rising edge of the pin only counts when it is a wake pin
  assign standby_wake = (r.wpin_en & i_wake_pin & ~r.wake_pin_q)
                      | i_rtc_event | ~i_external_reset_pin_n
                      | i_independent_watchdog_rst;
  // pin high level while enabled, or an rtc wake, raise the flag
  assign flag_set     = (r.wpin_en & i_wake_pin) | i_rtc_event;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    lpmc_pkg::lpmc_state_t tgt;
    tgt = pick_mode(i_deep_sleep_request, r.reg_pd, r.wflag);
    next_r              = r;
    next_r.wake_pin_q   = i_wake_pin;
    next_r.take_irq     = 1'b0;
    next_r.resume_event = 1'b0;
    next_r.rvalid       = i_reg_rd;

    // register writes; clear strobes read back as zero
    if (wr_ctrl) begin
      next_r.reg_lp = i_reg_wdata[lpmc_pkg::CTRL_LP_BIT];
      next_r.reg_pd = i_reg_wdata[lpmc_pkg::CTRL_PD_BIT];
    end
    if (wr_csts) begin
      next_r.wpin_en = i_reg_wdata[lpmc_pkg::CSTS_WPEN_BIT];
    end

    // flag clear lands two cycles after the write; a set wins
    next_r.wclr_pipe = {r.wclr_pipe[0],
                        wr_ctrl & i_reg_wdata[lpmc_pkg::CTRL_WCLR_BIT]};
    next_r.wflag = flag_set | (r.wflag & ~r.wclr_pipe[1]);

    // standby flag cleared by the clear bit, entry below wins
    if (wr_ctrl && i_reg_wdata[lpmc_pkg::CTRL_SCLR_BIT]) begin
      next_r.sbflag = 1'b0;
    end

    // power sequencing
    case (r.state)
      lpmc_pkg::ST_RUN: begin
        if (wait_cmd) begin
          next_r.via_event = ~i_wait_for_interrupt_instr;
          if (i_sleep_on_handler_return) begin
            next_r.target = tgt;
            next_r.state  = lpmc_pkg::ST_PEND;
          end else begin
            next_r.state = tgt;
          end
        end
      end
      lpmc_pkg::ST_PEND: begin
        // let the handler finish, then drop straight
        if (i_handler_return) begin
          next_r.state = r.target;
        end
      end
      lpmc_pkg::ST_SLEEP: begin
        // no added latency on the way out
        if (wake_match) begin
          next_r.state        = lpmc_pkg::ST_RUN;
          next_r.take_irq     = ~r.via_event;
          next_r.resume_event = r.via_event;
        end
      end
      lpmc_pkg::ST_STOP: begin
        if (wake_match) begin
          next_r.state = lpmc_pkg::ST_STOP_WAKE;
          next_r.cnt   = stop_exit_len(r.reg_lp) - 1'b1;
        end
      end
      lpmc_pkg::ST_STOP_WAKE: begin
        if (r.cnt == '0) begin
          next_r.state        = lpmc_pkg::ST_RUN;
          next_r.take_irq     = ~r.via_event;
          next_r.resume_event = r.via_event;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      lpmc_pkg::ST_STANDBY: begin
        if (standby_wake) begin
          next_r.state = lpmc_pkg::ST_RST_HOLD;
          next_r.cnt   = lpmc_pkg::CNT_W'(RST_CYC - 1);
        end
      end
      lpmc_pkg::ST_RST_HOLD: begin
        // control bits cleared by the standby exit reset
        next_r.reg_lp = 1'b0;
        next_r.reg_pd = 1'b0;
        if (r.cnt == '0) begin
          next_r.state = lpmc_pkg::ST_RUN;       // restart from reset
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      default: begin
        next_r.state = lpmc_pkg::ST_RUN;
      end
    endcase

    if (next_r.state == lpmc_pkg::ST_STANDBY) begin
      next_r.sbflag = 1'b1;
    end

    // outputs follow the next state so they line up with r.state
    next_r.core_halt   = next_r.state inside {lpmc_pkg::ST_SLEEP,
                         lpmc_pkg::ST_STOP, lpmc_pkg::ST_STOP_WAKE,
                         lpmc_pkg::ST_STANDBY};
    next_r.periph_halt = next_r.state inside {lpmc_pkg::ST_STOP,
                         lpmc_pkg::ST_STOP_WAKE,
                         lpmc_pkg::ST_STANDBY};
    next_r.reg_low_power = (next_r.state == lpmc_pkg::ST_STOP)
                         & next_r.reg_lp;
    next_r.domain_off  = next_r.state == lpmc_pkg::ST_STANDBY;
    next_r.chip_reset  = next_r.state == lpmc_pkg::ST_RST_HOLD;

    // read answer one cycle after the strobe; unmapped reads zero
    next_r.rdata = 32'h0000_0000;
    if (i_reg_rd && i_reg_addr == lpmc_pkg::CTRL_OFS) begin
      next_r.rdata[lpmc_pkg::CTRL_LP_BIT] = r.reg_lp;
      next_r.rdata[lpmc_pkg::CTRL_PD_BIT] = r.reg_pd;
    end else if (i_reg_rd && i_reg_addr == lpmc_pkg::CSTS_OFS) begin
      next_r.rdata[lpmc_pkg::CSTS_WFLAG_BIT]  = r.wflag;
      next_r.rdata[lpmc_pkg::CSTS_SBFLAG_BIT] = r.sbflag;
      next_r.rdata[lpmc_pkg::CSTS_WPEN_BIT]   = r.wpin_en;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      r        <= '0;
      r.state  <= lpmc_pkg::ST_RUN;
      r.target <= lpmc_pkg::ST_RUN;
      r.reg_lp <= lpmc_pkg::CTRL_RST[lpmc_pkg::CTRL_LP_BIT];
      r.reg_pd <= lpmc_pkg::CTRL_RST[lpmc_pkg::CTRL_PD_BIT];
      r.sbflag <= lpmc_pkg::CSTS_RST[lpmc_pkg::CSTS_SBFLAG_BIT];
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the flops
  assign o_reg_rdata           = r.rdata;
  assign o_reg_rvalid          = r.rvalid;
  assign o_power_state         = r.state;
  assign o_core_clk_halt       = r.core_halt;
  assign o_periph_clk_halt     = r.periph_halt;
  assign o_regulator_low_power = r.reg_low_power;
  assign o_domain_power_off    = r.domain_off;
  assign o_chip_reset          = r.chip_reset;
  assign o_take_interrupt      = r.take_irq;
  assign o_resume_event        = r.resume_event;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  logic [lpmc_pkg::CNT_W-1:0] wake_len;
  always_ff @(posedge i_core_clk) begin
    if (r.state != lpmc_pkg::ST_STOP_WAKE) begin
      wake_len <= '0;
    end else begin
      wake_len <= wake_len + 1'b1;
    end
  end

  sequence s_run_wait;
    r.state == lpmc_pkg::ST_RUN && wait_cmd && !i_sleep_on_handler_return;
  endsequence

  property p_sleep_now;
    s_run_wait and (!i_deep_sleep_request) |=> r.state == lpmc_pkg::ST_SLEEP;
  endproperty
  a_sleep_now: assert property (p_sleep_now) else $error("no sleep");

  property p_pend;
    r.state == lpmc_pkg::ST_RUN && wait_cmd && i_sleep_on_handler_return
      |=> r.state == lpmc_pkg::ST_PEND && !o_core_clk_halt;
  endproperty
  a_pend: assert property (p_pend) else $error("no pend");

  property p_wfe_ignores_irq;
    r.state == lpmc_pkg::ST_SLEEP && r.via_event && !i_wake_event
      |=> r.state == lpmc_pkg::ST_SLEEP;
  endproperty
  a_wfe_ignores_irq: assert property (p_wfe_ignores_irq)
    else $error("left sleep without event");

  property p_sleep_clocks;
    r.state == lpmc_pkg::ST_SLEEP |-> o_core_clk_halt && !o_periph_clk_halt;
  endproperty
  a_sleep_clocks: assert property (p_sleep_clocks)
    else $error("sleep gates wrong");

  property p_irq_wake;
    r.state == lpmc_pkg::ST_SLEEP && !r.via_event && i_irq_pending
      |=> o_take_interrupt && !o_resume_event && !o_core_clk_halt;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("irq wake");

  property p_stop_now;
    s_run_wait and (i_deep_sleep_request && !r.reg_pd)
      |=> r.state == lpmc_pkg::ST_STOP && o_periph_clk_halt;
  endproperty
  a_stop_now: assert property (p_stop_now) else $error("no stop");

  property p_stop_reg;
    r.state == lpmc_pkg::ST_STOP |-> o_regulator_low_power == r.reg_lp;
  endproperty
  a_stop_reg: assert property (p_stop_reg) else $error("regulator");

  property p_stop_exit_len;
    $past(r.state) == lpmc_pkg::ST_STOP_WAKE && r.state == lpmc_pkg::ST_RUN
      |-> wake_len == stop_exit_len(r.reg_lp);
  endproperty
  a_stop_exit_len: assert property (p_stop_exit_len)
    else $error("stop exit length");

  property p_standby_block;
    s_run_wait and (i_deep_sleep_request && r.reg_pd && r.wflag)
      |=> r.state == lpmc_pkg::ST_RUN;
  endproperty
  a_standby_block: assert property (p_standby_block)
    else $error("standby not blocked");

  property p_standby_flag;
    r.state == lpmc_pkg::ST_STANDBY |-> r.sbflag && o_domain_power_off;
  endproperty
  a_standby_flag: assert property (p_standby_flag)
    else $error("standby flag");

  property p_reset_hold;
    r.state == lpmc_pkg::ST_STANDBY && standby_wake
      |=> o_chip_reset ##1 (!r.reg_lp && !r.reg_pd);
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("exit reset");

  sequence s_wclr;
    wr_ctrl && i_reg_wdata[lpmc_pkg::CTRL_WCLR_BIT] && !flag_set;
  endsequence

  property p_wclr;
    s_wclr ##1 !flag_set ##1 !flag_set |=> !r.wflag;
  endproperty
  a_wclr: assert property (p_wclr) else $error("wake flag clear");

endmodule

`default_nettype wire

// file: verif/lpmc_core_model.sv
// core-side partner: wait instructions, sleep indications, interrupts
// assumes the bench calls its tasks; every change lands on a falling edge
`timescale 1ns/100ps
`default_nettype none

module lpmc_core_model (
  input  wire logic i_core_clk,
  input  wire logic i_take_interrupt,
  output logic      o_wfi,
  output logic      o_wfe,
  output logic      o_deep,
  output logic      o_on_exit,
  output logic      o_ret,
  output logic      o_irq,
  output logic      o_event
);
  // --------
  // core behaviour
  // --------
  initial begin
    {o_wfi, o_wfe, o_deep, o_on_exit, o_ret, o_irq, o_event} = 7'h00;
  end

  // handler entry retires the pending request, so no second wake follows
  always @(negedge i_core_clk) begin
    if (i_take_interrupt === 1'b1) begin
      o_irq <= 1'b0;
    end
  end

  // one-cycle wait pulse, indications set in the same cycle
  task automatic do_wait(input logic ev, input logic deep, input logic ox);
    @(negedge i_core_clk);
    o_deep    = deep;
    o_on_exit = ox;
    o_wfi     = ~ev;
    o_wfe     = ev;
    @(negedge i_core_clk);
    o_wfi = 1'b0;
    o_wfe = 1'b0;
  endtask

  task automatic set_deep(input logic v);
    @(negedge i_core_clk);
    o_deep = v;
  endtask

  task automatic set_irq(input logic v);
    @(negedge i_core_clk);
    o_irq = v;
  endtask

  task automatic pulse_ret;
    @(negedge i_core_clk);
    o_ret = 1'b1;
    @(negedge i_core_clk);
    o_ret = 1'b0;
  endtask

  task automatic pulse_event;
    @(negedge i_core_clk);
    o_event = 1'b1;
    @(negedge i_core_clk);
    o_event = 1'b0;
  endtask
endmodule

`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the low-power mode controller
// assumes lpmc_core_model beside it; inputs change on falling edges
`timescale 1ns/100ps
`default_nettype none

module tb;
  // short latencies keep every wake count small
  localparam int          OSC    = 2;
  localparam int          REG    = 3;
  localparam int          RST    = 4;
  localparam logic [7:0]  A_CTRL = lpmc_pkg::CTRL_OFS;
  localparam logic [7:0]  A_STAT = lpmc_pkg::CSTS_OFS;
  localparam logic [31:0] ALL    = 32'hffff_ffff;

  logic        clk;
  logic        rst;
  logic        wake_pin;
  logic        rtc_ev;
  logic        rst_pin_n;
  logic        wdog;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        rvalid;
  logic [6:0]  st;
  logic        core_halt;
  logic        per_halt;
  logic        reg_lp;
  logic        pwr_off;
  logic        chip_rst;
  logic        take;
  logic        resume;
  logic        wait_for_interrupt_instr;
  logic        wait_for_event_instr;
  logic        deep;
  logic        on_exit;
  logic        ret;
  logic        irq;
  logic        ev;
  int          errors;
  int          tests_run;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  lpmc_core_model core (
    .i_core_clk       (clk),
    .i_take_interrupt (take),
    .o_wfi            (wait_for_interrupt_instr),
    .o_wfe            (wait_for_event_instr),
    .o_deep           (deep),
    .o_on_exit        (on_exit),
    .o_ret            (ret),
    .o_irq            (irq),
    .o_event          (ev)
  );

  lpmc_ctrl #(.OSC_CYC(OSC), .REG_CYC(REG), .RST_CYC(RST)) i_dut (
    .i_core_clk                 (clk),
    .i_rst                      (rst),
    .i_wait_for_interrupt_instr (wait_for_interrupt_instr),
    .i_wait_for_event_instr     (wait_for_event_instr),
    .i_deep_sleep_request       (deep),
    .i_sleep_on_handler_return  (on_exit),
    .i_handler_return           (ret),
    .i_irq_pending              (irq),
    .i_wake_event               (ev),
    .i_wake_pin                 (wake_pin),
    .i_rtc_event                (rtc_ev),
    .i_external_reset_pin_n     (rst_pin_n),
    .i_independent_watchdog_rst (wdog),
    .i_reg_wr                   (wr),
    .i_reg_rd                   (rd),
    .i_reg_addr                 (addr),
    .i_reg_wdata                (wdata),
    .o_reg_rdata                (rdata),
    .o_reg_rvalid               (rvalid),
    .o_power_state              (st),
    .o_core_clk_halt            (core_halt),
    .o_periph_clk_halt          (per_halt),
    .o_regulator_low_power      (reg_lp),
    .o_domain_power_off         (pwr_off),
    .o_chip_reset               (chip_rst),
    .o_take_interrupt           (take),
    .o_resume_event             (resume)
  );

  // --------
  // helpers
  // --------
  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic st_chk(input logic [6:0] e);
    check("power_state", {25'h000_0000, st}, {25'h000_0000, e});
  endtask

  task automatic bit_chk(input string nm, input logic g, input logic e);
    check(nm, {31'h0000_0000, g}, {31'h0000_0000, e});
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    wr    = 1'b1;
    addr  = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // read answers one cycle after the strobe edge; m masks unknown fields
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    @(negedge clk);
    rd   = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    bit_chk("rvalid", rvalid, 1'b1);
    check("rdata", rdata & m, e);
  endtask

  // falling edges spent in one state, bounded so a stuck state ends
  task automatic dwell(input logic [6:0] s, output int n);
    n = 0;
    while (st === s && n < 1000) begin
      n++;
      @(negedge clk);
    end
  endtask

  // 0 wake pin rise, 1 rtc event, 2 reset pin, 3 watchdog
  task automatic pulse_src(input int s);
    logic [3:0] sel;
    sel = 4'h1 << s[1:0];
    @(negedge clk);
    wake_pin  = sel[0];
    rtc_ev    = sel[1];
    rst_pin_n = ~sel[2];
    wdog      = sel[3];
    @(negedge clk);
    {wake_pin, rtc_ev, wdog} = 3'h0;
    rst_pin_n = 1'b1;
  endtask

  // --------
  // scenarios
  // --------
  task automatic t_regs;
    rd_chk(A_CTRL, ALL, 32'h0000_0000);
    rd_chk(A_STAT, ALL, 32'h0000_0000);
    rd_chk(8'h08, ALL, 32'h0000_0000);
    reg_wr(A_CTRL, 32'h0000_000F);
    rd_chk(A_CTRL, ALL, 32'h0000_0003);
    reg_wr(A_CTRL, 32'h0000_0000);
    rd_chk(A_CTRL, ALL, 32'h0000_0000);
  endtask

  task automatic t_sleep;
    core.do_wait(1'b0, 1'b0, 1'b0);
    st_chk(lpmc_pkg::ST_SLEEP);
    bit_chk("core_halt", core_halt, 1'b1);
    bit_chk("periph_halt", per_halt, 1'b0);
    core.set_irq(1'b1);
    @(negedge clk);
    st_chk(lpmc_pkg::ST_RUN);
    bit_chk("take", take, 1'b1);
    bit_chk("resume", resume, 1'b0);
    core.do_wait(1'b1, 1'b0, 1'b0);
    core.set_irq(1'b1);
    repeat (3) @(negedge clk);
    st_chk(lpmc_pkg::ST_SLEEP);
    core.set_irq(1'b0);
    core.pulse_event;
    st_chk(lpmc_pkg::ST_RUN);
    bit_chk("resume", resume, 1'b1);
    bit_chk("take", take, 1'b0);
  endtask

  // deep-sleep rises while pending: the target stays the sampled one
  task automatic t_on_exit;
    core.do_wait(1'b0, 1'b0, 1'b1);
    st_chk(lpmc_pkg::ST_PEND);
    core.set_deep(1'b1);
    repeat (2) @(negedge clk);
    st_chk(lpmc_pkg::ST_PEND);
    core.pulse_ret;
    st_chk(lpmc_pkg::ST_SLEEP);
    core.set_irq(1'b1);
    @(negedge clk);
    st_chk(lpmc_pkg::ST_RUN);
    core.set_deep(1'b0);
  endtask

  task automatic t_stop(input logic lp, input logic e);
    int n;
    reg_wr(A_CTRL, {31'h0000_0000, lp});
    core.do_wait(e, 1'b1, 1'b0);
    st_chk(lpmc_pkg::ST_STOP);
    bit_chk("periph_halt", per_halt, 1'b1);
    bit_chk("reg_low_power", reg_lp, lp);
    core.set_irq(1'b1);
    if (e) begin
      repeat (3) @(negedge clk);
      st_chk(lpmc_pkg::ST_STOP);
      core.pulse_event;
    end else begin
      @(negedge clk);
    end
    dwell(lpmc_pkg::ST_STOP_WAKE, n);
    check("stop_exit_cycles", n, lp ? OSC + REG : OSC);
    st_chk(lpmc_pkg::ST_RUN);
    bit_chk("take", take, ~e);
    bit_chk("resume", resume, e);
    core.set_irq(1'b0);
  endtask

  task automatic t_block;
    reg_wr(A_STAT, 32'h0000_0100);
    reg_wr(A_CTRL, 32'h0000_0002);
    pulse_src(1);
    rd_chk(A_STAT, 32'h0000_0303, 32'h0000_0101);
    core.do_wait(1'b0, 1'b1, 1'b0);
    repeat (2) @(negedge clk);
    st_chk(lpmc_pkg::ST_RUN);
    reg_wr(A_CTRL, 32'h0000_0006);
    rd_chk(A_STAT, 32'h0000_0001, 32'h0000_0001);
    rd_chk(A_STAT, 32'h0000_0001, 32'h0000_0000);
  endtask

  task automatic t_standby(input int s);
    int n;
    // low-power bit set too, so the exit reset must clear both bits
    reg_wr(A_CTRL, 32'h0000_0007);
    repeat (3) @(negedge clk);
    core.do_wait(s[0], 1'b1, 1'b0);
    st_chk(lpmc_pkg::ST_STANDBY);
    bit_chk("power_off", pwr_off, 1'b1);
    bit_chk("periph_halt", per_halt, 1'b1);
    repeat (2) @(negedge clk);
    pulse_src(s);
    st_chk(lpmc_pkg::ST_RST_HOLD);
    bit_chk("chip_reset", chip_rst, 1'b1);
    dwell(lpmc_pkg::ST_RST_HOLD, n);
    check("reset_hold_cycles", n, RST);
    st_chk(lpmc_pkg::ST_RUN);
    bit_chk("wake_pulse", take | resume, 1'b0);
    rd_chk(A_CTRL, ALL, 32'h0000_0000);
    rd_chk(A_STAT, 32'h0000_0302, 32'h0000_0102);
    reg_wr(A_CTRL, 32'h0000_000C);
    repeat (3) @(negedge clk);
    rd_chk(A_STAT, 32'h0000_0303, 32'h0000_0100);
  endtask

  // --------
  // run control
  // --------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    rst       = 1'b1;
    wake_pin  = 1'b0;
    rtc_ev    = 1'b0;
    rst_pin_n = 1'b1;
    wdog      = 1'b0;
    wr        = 1'b0;
    rd        = 1'b0;
    addr      = 8'h00;
    wdata     = 32'h0000_0000;
    errors    = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    st_chk(lpmc_pkg::ST_RUN);
    t_regs;
    t_sleep;
    t_on_exit;
    t_stop(1'b0, 1'b0);
    t_stop(1'b1, 1'b1);
    t_block;
    for (int s = 0; s < 4; s++) begin
      t_standby(s);
    end
    end_sim;
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    end_sim;
  end
endmodule

`default_nettype wire
